// ---- logic/spdma_port.sv ----
/*
  One synchronous serial port with its byte-moving engine and the
  general purpose memory the engine reads and writes.
  Assumes pins arrive unsynchronised, the shared timebase tick is a
  one-cycle pulse from the same clock, and an Avalon-MM master.
*/
// Local design decisions: the register offsets and the Avalon-MM register port.
module spdma_port
  import spdma_pkg::*;
#(
  parameter bit HAS_DMA = 1'b1,
  parameter int MEM_AW = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  // register bus
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // shared timebase
  input wire logic timebase_tick,
  // serial pins
  input wire logic second_port_serial_clock_i,
  output logic second_port_serial_clock_o,
  output logic second_port_serial_clock_oe,
  input wire logic second_port_serial_in,
  output logic second_port_serial_out,
  output logic second_port_serial_out_oe,
  input wire logic second_port_slave_select_n,
  // power management
  output logic wake
);

  typedef enum {DM_IDLE, DM_KICK, DM_SHIFT, DM_STORE} spdma_dm_e;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [8:0] ctrl_q;
  logic irq_flag_q, wake_q, waitreq_q;
  logic [31:0] readdata_q;
  logic dma_en_q;
  logic [1:0] dmode_q;
  logic [3:0] lvl_q;
  logic [9:0] cnt_q;
  logic [11:0] txptr_q, rxptr_q;
  logic [MEM_AW-1:0] maddr_q;
  logic [7:0] mem_q [0:(2**MEM_AW)-1];
  logic sck_s1, sck_s2, sck_s3, sdi_s1, sdi_s2, ss_s1, ss_s2;
  logic busy_q, done_q, sck_o_q, out_q, out_oe_q, lvl_hit_q, sck_oe_q;
  logic [3:0] edge_q;
  logic [2:0] bits_q;
  logic [5:0] div_q;
  logic [7:0] tx_sr_q, rx_sr_q, rx_q, tx_buf_q;
  spdma_dm_e st_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [3:0] rate;
  logic cpol, cpha, sample_point_select, port_en, irq_en, master, slave, slave_on, adv;
  logic bus_go, bus_wr, bus_rd, go, dma_kick, dma_store, dma_last;
  logic half_tick, sck_edge, lead, trail, sample_ev, shift_ev, lvl_hit;
  logic [7:0] rx_next, kick_byte, go_byte, mem_rd;
  logic [31:0] rd_d;

  assign rate = ctrl_q[3:0];
  assign cpol = ctrl_q[CTL_CPOL];
  // edge bit set means data changes leaving active level, i.e. phase 0
  assign cpha = ~ctrl_q[CTL_CKE];
  assign sample_point_select = ctrl_q[CTL_SMP];
  assign port_en = ctrl_q[CTL_EN];
  assign irq_en = ctrl_q[CTL_IE];
  assign master = port_en && (rate <= RATE_TMR);
  assign slave = port_en && (rate == RATE_SLV_SS || rate == RATE_SLV_NOSS);
  assign slave_on = slave && (rate == RATE_SLV_NOSS || !ss_s2);
  // slave logic keeps running with the clock enable low
  assign adv = clock_en || slave;

  assign bus_go = clock_en && (read || write) && !waitreq_q;
  assign bus_wr = bus_go && write;
  assign bus_rd = bus_go && read;

  // ----------------------------------------------------------------
  // register bus: one wait cycle on every access
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    case (address)
      OFS_CTRL1: rd_d[8:0] = ctrl_q;
      OFS_STATUS: rd_d[2:0] = {wake_q, busy_q, irq_flag_q};
      OFS_DATA: rd_d[7:0] = rx_q;
      OFS_DMACTL: rd_d[2:0] = {dmode_q, dma_en_q};
      OFS_DMALVL: rd_d[3:0] = lvl_q;
      OFS_COUNT: rd_d[9:0] = cnt_q;
      OFS_TXPTR: rd_d[11:0] = txptr_q;
      OFS_RXPTR: rd_d[11:0] = rxptr_q;
      OFS_MADDR: rd_d[MEM_AW-1:0] = maddr_q;
      OFS_MDATA: rd_d[7:0] = mem_q[maddr_q];
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      waitreq_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end else if (clock_en) begin
      if ((read || write) && waitreq_q) begin
        waitreq_q <= 1'b0;
        readdata_q <= read ? rd_d : 32'h0000_0000;
      end else begin
        waitreq_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_q <= CTRL1_RST;
    end else if (bus_wr && address == OFS_CTRL1) begin
      ctrl_q <= writedata[8:0];
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {sdi_s1, sdi_s2} <= 2'h0;
      {ss_s1, ss_s2} <= 2'h3;
    end else if (adv) begin
      sck_s1 <= second_port_serial_clock_i;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sdi_s1 <= second_port_serial_in;
      sdi_s2 <= sdi_s1;
      ss_s1 <= second_port_slave_select_n;
      ss_s2 <= ss_s1;
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  // the timer rate toggles on each shared tick, so both instances on it
  // move together when the timer is reprogrammed
  assign half_tick = master && busy_q &&
    ((rate == RATE_TMR) ? timebase_tick
                        : (div_q == half_period(rate) - 6'h01));
  assign sck_edge = slave_on && (sck_s2 != sck_s3);
  assign lead = master ? (half_tick && sck_o_q == cpol)
                       : (sck_edge && sck_s2 != cpol);
  assign trail = master ? (half_tick && sck_o_q != cpol)
                        : (sck_edge && sck_s2 == cpol);
  // sample point late only for a master in phase 0
  assign sample_ev = cpha ? trail : ((sample_point_select && master) ? trail : lead);
  assign shift_ev = cpha ? lead : trail;
  assign rx_next = {rx_sr_q[6:0], sdi_s2};
  assign go = master && !busy_q && (dma_kick ||
    (bus_wr && address == OFS_DATA && !dma_en_q));
  assign go_byte = dma_kick ? kick_byte : writedata[7:0];

  always_ff @(posedge clock) begin
    if (reset || !port_en) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      edge_q <= 4'h0;
      bits_q <= 3'h0;
      div_q <= 6'h00;
      sck_o_q <= reset ? 1'b0 : cpol;
      out_q <= 1'b0;
      out_oe_q <= 1'b0;
      sck_oe_q <= 1'b0;
      tx_sr_q <= 8'h00;
      rx_sr_q <= 8'h00;
      if (reset) begin
        rx_q <= 8'h00;
        tx_buf_q <= 8'h00;
      end
    end else if (adv) begin
      done_q <= 1'b0;
      out_oe_q <= master || slave_on;
      sck_oe_q <= master;
      if ((dma_kick && slave) ||
          (bus_wr && address == OFS_DATA && !dma_en_q)) begin
        tx_buf_q <= go_byte;
      end
      if (sample_ev) begin
        rx_sr_q <= rx_next;
        bits_q <= bits_q + 3'h1;
      end
      if (shift_ev && !(cpha == 1'b0 && bits_q == 3'h0 && slave)) begin
        out_q <= tx_sr_q[7];
        tx_sr_q <= {tx_sr_q[6:0], 1'b0};
      end
      if (master) begin
        if (!busy_q) begin
          sck_o_q <= cpol;
          div_q <= 6'h00;
          if (go) begin
            busy_q <= 1'b1;
            edge_q <= 4'h0;
            bits_q <= 3'h0;
            out_q <= cpha ? out_q : go_byte[7];
            tx_sr_q <= cpha ? go_byte : {go_byte[6:0], 1'b0};
          end
        end else begin
          div_q <= half_tick ? 6'h00 : div_q + 6'h01;
          if (half_tick) begin
            sck_o_q <= ~sck_o_q;
            edge_q <= edge_q + 4'h1;
            if (edge_q == LAST_EDGE) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              rx_q <= sample_ev ? rx_next : rx_sr_q;
            end
          end
        end
      end else begin
        sck_o_q <= cpol;
        // deselect drops a partial byte and reloads the next one
        if (!slave_on || (sample_ev && bits_q == LAST_BIT)) begin
          bits_q <= 3'h0;
          out_q <= cpha ? out_q : tx_buf_q[7];
          tx_sr_q <= cpha ? tx_buf_q : {tx_buf_q[6:0], 1'b0};
        end
        if (slave_on && sample_ev && bits_q == LAST_BIT) begin
          done_q <= 1'b1;
          rx_q <= rx_next;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // byte-moving engine
  // ----------------------------------------------------------------
  // source reads are async and never write back, so memory stays intact
  assign mem_rd = in_sfr(txptr_q) ? 8'h00
                                  : mem_q[txptr_q[MEM_AW-1:0]];
  assign kick_byte = (dmode_q == DMODE_HALF_RX) ? DUMMY_TX : mem_rd;
  assign dma_kick = HAS_DMA && st_q == DM_KICK;
  assign dma_store = st_q == DM_STORE;
  assign dma_last = dma_store && cnt_q == 10'h000;

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= DM_IDLE;
    end else if (adv) begin
      case (st_q)
        DM_IDLE: if (HAS_DMA && dma_en_q && port_en) st_q <= DM_KICK;
        DM_KICK: st_q <= DM_SHIFT;
        // next byte waits for the whole previous one
        DM_SHIFT: if (done_q) st_q <= DM_STORE;
        DM_STORE: st_q <= dma_last ? DM_IDLE : DM_KICK;
        default: st_q <= DM_IDLE;
      endcase
      if (!dma_en_q || !port_en) st_q <= DM_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dma_en_q <= 1'b0;
      dmode_q <= DMODE_RST;
      lvl_q <= LVL_RST;
      cnt_q <= COUNT_RST;
      txptr_q <= PTR_RST;
      rxptr_q <= PTR_RST;
    end else if (adv) begin
      if (bus_wr) begin
        case (address)
          OFS_DMACTL: begin
            dma_en_q <= HAS_DMA && writedata[DMA_EN_BIT];
            dmode_q <= writedata[2:1];
          end
          OFS_DMALVL: lvl_q <= writedata[3:0];
          OFS_COUNT: cnt_q <= writedata[9:0];
          OFS_TXPTR: txptr_q <= writedata[11:0];
          OFS_RXPTR: rxptr_q <= writedata[11:0];
          default: ;
        endcase
      end
      if (dma_store) begin
        if (dma_last) begin
          dma_en_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 10'h001;
        end
        if (dmode_q != DMODE_HALF_RX) txptr_q <= txptr_q + 12'h001;
        if (dmode_q != DMODE_HALF_TX) rxptr_q <= rxptr_q + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // general purpose memory, engine store wins over a bus write
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (adv && dma_store && dmode_q != DMODE_HALF_TX &&
        !in_sfr(rxptr_q)) begin
      mem_q[rxptr_q[MEM_AW-1:0]] <= rx_q;
    end else if (bus_wr && address == OFS_MDATA) begin
      mem_q[maddr_q] <= writedata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      maddr_q <= '0;
    end else if (bus_wr && address == OFS_MADDR) begin
      maddr_q <= writedata[MEM_AW-1:0];
    end else if ((bus_wr || bus_rd) && address == OFS_MDATA) begin
      maddr_q <= maddr_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // flag and wake
  // ----------------------------------------------------------------
  assign lvl_hit = dma_en_q && level_bytes(lvl_q) != 11'h000 &&
    ({1'b0, cnt_q} + 11'h001 <= level_bytes(lvl_q));

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_flag_q <= 1'b0;
      lvl_hit_q <= 1'b0;
    end else if (adv) begin
      lvl_hit_q <= lvl_hit;
      // a set in the clearing cycle wins
      if ((done_q && !dma_en_q) || (lvl_hit && !lvl_hit_q) ||
          (adv && dma_last)) begin
        irq_flag_q <= 1'b1;
      end else if (bus_wr && address == OFS_STATUS &&
                   writedata[STS_FLAG]) begin
        irq_flag_q <= 1'b0;
      end
    end
  end

  // wake must work while the clock enable is low
  always_ff @(posedge clock) begin
    if (reset) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= irq_flag_q && irq_en;
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitreq_q;
  assign second_port_serial_clock_o = sck_o_q;
  assign second_port_serial_clock_oe = sck_oe_q;
  assign second_port_serial_out = out_q;
  assign second_port_serial_out_oe = out_oe_q;
  assign wake = wake_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  idle_polarity_a: assert property (@(posedge clock) disable iff (reset)
    (clock_en && master && !busy_q) |=> sck_o_q == $past(cpol))
    else $error("idle serial clock differs from polarity");
  reset_abort_a: assert property (@(posedge clock)
    reset |=> (!busy_q && !port_en && !dma_en_q && st_q == DM_IDLE))
    else $error("reset left port enabled or transfer running");
  sleep_freeze_a: assert property (@(posedge clock) disable iff (reset)
    (!clock_en && master && busy_q) |=> ($stable(edge_q) && $stable(sck_o_q)
      && $stable(tx_sr_q)))
    else $error("master transfer moved while clock enable low");
  byte_flag_a: assert property (@(posedge clock) disable iff (reset)
    (done_q && !dma_en_q && adv) |=> irq_flag_q)
    else $error("flag missing after finished byte");
  wake_follow_a: assert property (@(posedge clock) disable iff (reset)
    wake_q == $past(irq_flag_q && irq_en))
    else $error("wake output does not follow enabled flag");
  count_step_a: assert property (@(posedge clock) disable iff (reset)
    (adv && dma_store && cnt_q != 10'h000 && !bus_wr)
      |=> cnt_q == $past(cnt_q) - 10'h001)
    else $error("byte counter did not step down by one");
  dma_finish_a: assert property (@(posedge clock) disable iff (reset)
    (adv && dma_last) |=> (!dma_en_q && cnt_q == 10'h000 && irq_flag_q)
      ##1 st_q == DM_IDLE)
    else $error("engine did not stop cleanly after last byte");
  src_step_a: assert property (@(posedge clock) disable iff (reset)
    (adv && dma_store && dmode_q == DMODE_FULL && !bus_wr)
      |=> txptr_q == $past(txptr_q) + 12'h001)
    else $error("source pointer did not advance");
  sfr_guard_a: assert property (@(posedge clock) disable iff (reset)
    (dma_kick && in_sfr(txptr_q) && dmode_q != DMODE_HALF_RX)
      |-> kick_byte == 8'h00)
    else $error("engine read from special function area");
  level_now_a: assert property (@(posedge clock) disable iff (reset)
    (adv && lvl_hit && !lvl_hit_q) |=> irq_flag_q)
    else $error("level crossing did not raise flag at once");
  serial_order_a: assert property (@(posedge clock) disable iff (reset)
    (dma_kick && adv && dma_en_q && port_en)
      |-> ##1 (st_q == DM_SHIFT && !dma_kick))
    else $error("engine kicked a byte while one was shifting");

endmodule : spdma_port

// ---- logic/spdma_pkg.sv ----
/*
  Constants shared by the serial port with byte-moving engine: register
  offsets, field positions, reset values, rate codes and level table.
  Assumes a byte-addressed Avalon-MM slave with 32-bit data.
*/
package spdma_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL1 = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_DATA = 6'h08;
  localparam logic [5:0] OFS_DMACTL = 6'h0C;
  localparam logic [5:0] OFS_DMALVL = 6'h10;
  localparam logic [5:0] OFS_COUNT = 6'h14;
  localparam logic [5:0] OFS_TXPTR = 6'h18;
  localparam logic [5:0] OFS_RXPTR = 6'h1C;
  localparam logic [5:0] OFS_MADDR = 6'h20;
  localparam logic [5:0] OFS_MDATA = 6'h24;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_CPOL = 4;
  localparam int CTL_CKE = 5;
  localparam int CTL_SMP = 6;
  localparam int CTL_EN = 7;
  localparam int CTL_IE = 8;
  localparam logic [8:0] CTRL1_RST = 9'h000;
  localparam int STS_FLAG = 0;
  localparam int DMA_EN_BIT = 0;
  localparam logic [1:0] DMODE_RST = 2'h0;
  localparam logic [3:0] LVL_RST = 4'h0;
  localparam logic [9:0] COUNT_RST = 10'h000;
  localparam logic [11:0] PTR_RST = 12'h000;

  // ----------------------------------------------------------------
  // rate/mode codes and engine constants
  // ----------------------------------------------------------------
  localparam logic [3:0] RATE_DIV4 = 4'h0;
  localparam logic [3:0] RATE_DIV16 = 4'h1;
  localparam logic [3:0] RATE_DIV64 = 4'h2;
  localparam logic [3:0] RATE_TMR = 4'h3;
  localparam logic [3:0] RATE_SLV_SS = 4'h4;
  localparam logic [3:0] RATE_SLV_NOSS = 4'h5;
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] DMODE_HALF_TX = 2'h0;
  localparam logic [1:0] DMODE_HALF_RX = 2'h1;
  localparam logic [1:0] DMODE_FULL = 2'h2;
  localparam logic [11:0] SFR_BASE = 12'hE00;
  localparam logic [7:0] DUMMY_TX = 8'hFF;

  // clock cycles per half serial period for the divided rates
  function automatic logic [5:0] half_period(input logic [3:0] rate);
    case (rate)
      RATE_DIV16: half_period = HALF_DIV16;
      RATE_DIV64: half_period = HALF_DIV64;
      default: half_period = HALF_DIV4;
    endcase
  endfunction : half_period

  // remaining-byte threshold per level code; zero means completion only
  function automatic logic [10:0] level_bytes(input logic [3:0] lvl);
    case (lvl)
      4'h1: level_bytes = 11'h001;
      4'h2: level_bytes = 11'h002;
      4'h3: level_bytes = 11'h004;
      4'h4: level_bytes = 11'h008;
      4'h5: level_bytes = 11'h010;
      4'h6: level_bytes = 11'h020;
      4'h7: level_bytes = 11'h040;
      4'h8: level_bytes = 11'h060;
      4'h9: level_bytes = 11'h080;
      4'hA: level_bytes = 11'h0C0;
      4'hB: level_bytes = 11'h100;
      4'hC: level_bytes = 11'h140;
      4'hD: level_bytes = 11'h180;
      4'hE: level_bytes = 11'h1C0;
      4'hF: level_bytes = 11'h240;
      default: level_bytes = 11'h000;
    endcase
  endfunction : level_bytes

  // banks 14 and 15 are out of reach of the engine
  function automatic logic in_sfr(input logic [11:0] a);
    in_sfr = (a >= SFR_BASE);
  endfunction : in_sfr

endpackage : spdma_pkg

// ---- dv/spdma_peer.sv ----
/*
  Serial peer for the port in master mode 0,0: sends a rising byte
  sequence and records what it receives.
  Assumes the port drives the serial clock and samples on rising edges.
*/
module spdma_peer (
  // serial link
  input wire logic sclk,
  input wire logic mosi,
  input wire logic sel,
  output logic miso,
  // observation
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'hA5;
  logic [7:0] nxt = 8'hA5;
  logic [7:0] rx = 8'h00;
  int n = 0;
  // --------------------------------------------------------------
  // shifter
  // --------------------------------------------------------------
  // a released line shows the inverse, never a stale bit
  assign miso = sel ? sh[7] : ~sh[7];
  always @(posedge sclk) begin
    rx = {rx[6:0], mosi};
    n = n + 1;
    if (n == 8) got = rx;
  end
  always @(negedge sclk) begin
    if (n == 8) begin
      n = 0;
      nxt = nxt + 8'h11;
      sh = nxt;
    end else sh = {sh[6:0], 1'b0};
  end
endmodule : spdma_peer

// ---- dv/spi_port_with_dma_transfer_tb.sv ----
/*
  Self-checking bench for the serial port with byte-moving engine.
  Assumes the peer model and a 25 MHz system clock.
*/
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (e)); \
  end end
module spi_port_with_dma_transfer_tb import spdma_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, reset = 1'b1, clock_en = 1'b1;
  logic read = 1'b0, write = 1'b0, slv = 1'b0, sdi_b = 1'b0, tick = 1'b0;
  logic sck_i = 1'b0, waitrequest, sck_o, sck_oe, sdo, sdo_oe, wake, miso;
  logic [5:0] address = 6'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [7:0] got, pe, s;
  logic [7:0] src [3] = '{8'h3C, 8'hC3, 8'h81};
  int failures = 0, comparisons = 0;
  // --------------------------------------------------------------
  // structure
  // --------------------------------------------------------------
  spdma_port u_dut (.clock(clock), .reset(reset), .clock_en(clock_en),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .timebase_tick(tick),
    .second_port_serial_clock_i(sck_i),
    .second_port_serial_clock_o(sck_o),
    .second_port_serial_clock_oe(sck_oe),
    .second_port_serial_in(slv ? sdi_b : miso),
    .second_port_serial_out(sdo), .second_port_serial_out_oe(sdo_oe),
    .second_port_slave_select_n(1'b1), .wake(wake));
  spdma_peer u_peer (.sclk(sck_o), .mosi(sdo), .sel(sdo_oe),
    .miso(miso), .got(got));
  initial begin
    forever #20 clock = ~clock;
  end
  // shared timebase: one-cycle tick every second clock
  always @(posedge clock) tick <= ~tick;
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task finish_test;
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      failures++;
      finish_test();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus
  // polls a bit; bounded because a stuck engine must not hang the run
  task automatic wait_bit(input logic [5:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while (q[b] !== v && n < 2000);
    if (q[b] !== v) begin
      failures++;
      finish_test();
    end
  endtask : wait_bit
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    pe = 8'hA5;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    bus(1'b0, OFS_CTRL1, 32'h0);
    `CHK(q[8:0], CTRL1_RST)
    bus(1'b0, OFS_COUNT, 32'h0);
    `CHK(q[9:0], COUNT_RST)
    bus(1'b0, 6'h28, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, OFS_MADDR, 32'h100);
    for (int i = 0; i < 3; i++) bus(1'b1, OFS_MDATA, {24'h0, src[i]});
    // two rates, wake with and without irq enable
    for (int r = 0; r < 2; r++) begin
      // input synchroniser costs two clocks: fast rates need late sampling
      bus(1'b1, OFS_CTRL1, r ? 32'h0A1 : 32'h1E0);
      bus(1'b1, OFS_DATA, 32'h96 ^ r);
      wait_bit(OFS_STATUS, STS_FLAG, 1'b1);
      `CHK(got, 8'h96 ^ r)
      bus(1'b0, OFS_DATA, 32'h0);
      `CHK(q[7:0], pe)
      `CHK(wake, 1'(r == 0))
      pe = pe + 8'h11;
      bus(1'b1, OFS_STATUS, 32'h1);
    end
    // sleep in mid byte, then resume
    bus(1'b1, OFS_CTRL1, 32'h0E3);
    bus(1'b1, OFS_DATA, 32'h5C);
    repeat (20) @(posedge clock);
    clock_en <= 1'b0;
    repeat (2) @(posedge clock);
    s = {7'h0, sck_o};
    repeat (40) @(posedge clock);
    `CHK({7'h0, sck_o}, s)
    clock_en <= 1'b1;
    wait_bit(OFS_STATUS, STS_FLAG, 1'b1);
    `CHK(got, 8'h5C)
    pe = pe + 8'h11;
    bus(1'b1, OFS_STATUS, 32'h1);
    // engine, full duplex, three bytes
    bus(1'b1, OFS_CTRL1, 32'h0E0);
    bus(1'b1, OFS_COUNT, 32'h2);
    bus(1'b1, OFS_TXPTR, 32'h100);
    bus(1'b1, OFS_RXPTR, 32'h200);
    bus(1'b1, OFS_DMALVL, 32'hF);
    bus(1'b1, OFS_DMACTL, {29'h0, DMODE_FULL, 1'b1});
    // level far above the three bytes left flags at once
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[STS_FLAG], 1'b1)
    bus(1'b1, OFS_STATUS, 32'h1);
    wait_bit(OFS_DMACTL, DMA_EN_BIT, 1'b0);
    `CHK(got, src[2])
    bus(1'b0, OFS_COUNT, 32'h0);
    `CHK(q[9:0], 10'h000)
    bus(1'b0, OFS_TXPTR, 32'h0);
    `CHK(q[11:0], 12'h103)
    bus(1'b0, OFS_RXPTR, 32'h0);
    `CHK(q[11:0], 12'h203)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[STS_FLAG], 1'b1)
    bus(1'b1, OFS_MADDR, 32'h200);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, OFS_MDATA, 32'h0);
      `CHK(q[7:0], pe)
      pe = pe + 8'h11;
    end
    bus(1'b1, OFS_MADDR, 32'h100);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, OFS_MDATA, 32'h0);
      `CHK(q[7:0], src[i])
    end
    // engine fetch from the special function area
    bus(1'b1, OFS_COUNT, 32'h0);
    bus(1'b1, OFS_TXPTR, 32'hE00);
    bus(1'b1, OFS_DMACTL, {29'h0, DMODE_HALF_TX, 1'b1});
    wait_bit(OFS_DMACTL, DMA_EN_BIT, 1'b0);
    `CHK(got, 8'h00)
    bus(1'b1, OFS_STATUS, 32'h1);
    // slave byte shifted in while asleep
    bus(1'b1, OFS_CTRL1, 32'h185);
    slv <= 1'b1;
    clock_en <= 1'b0;
    s = 8'h5A;
    // phase 1: data moves on the leading edge, sampled on the trailing
    for (int i = 0; i < 8; i++) begin
      repeat (4) @(posedge clock);
      sck_i <= 1'b1;
      sdi_b <= s[7 - i];
      repeat (4) @(posedge clock);
      sck_i <= 1'b0;
    end
    repeat (8) @(posedge clock);
    `CHK(wake, 1'b1)
    clock_en <= 1'b1;
    bus(1'b0, OFS_DATA, 32'h0);
    `CHK(q[7:0], 8'h5A)
    slv <= 1'b0;
    // idle clock level per mode
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, OFS_CTRL1, 32'h80 | {26'h0, ~m[0], m[1], 4'h0});
      repeat (2) @(posedge clock);
      `CHK(sck_o, m[1])
    end
    // reset in mid byte
    bus(1'b1, OFS_CTRL1, 32'h0A1);
    bus(1'b1, OFS_DATA, 32'h11);
    repeat (10) @(posedge clock);
    `CHK(sck_oe, 1'b1)
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    `CHK(sck_oe, 1'b0)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[1], 1'b0)
    finish_test();
  end
endmodule : spi_port_with_dma_transfer_tb
